// ===== testbench/dms_master_model.sv
// Network master model polling the bank one word at a time
`timescale 1ns/10ps
`default_nettype none
module dms_master_model (
  input wire logic sys_clk_i, // Clock
  input wire logic rst_i, // Reset
  input wire logic go_i, // Start transfer
  input wire logic wr_i, // Write, not read
  input wire logic [15:0] base_i, // First register
  input wire logic [4:0] cnt_i, // Register count
  output dms_pkg::dms_req_t req_o, // Bus request
  output logic [5:0] len_o // Data length, bytes
);
  logic [4:0] left;
  // Successive single words; idle bus toggles so stale values never match
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      req_o <= '0;
      left <= 5'h00;
      len_o <= 6'h00;
    end else if (go_i && left == 5'h00) begin
      req_o.rd <= !wr_i;
      req_o.wr <= wr_i;
      req_o.addr <= base_i;
      req_o.wdata <= 16'hFFFF;
      left <= cnt_i - 5'h01;
      len_o <= {cnt_i, 1'b0};
    end else if (left != 5'h00) begin
      req_o.addr <= req_o.addr + 16'h0001;
      left <= left - 5'h01;
    end else begin
      req_o.rd <= 1'b0;
      req_o.wr <= 1'b0;
      req_o.addr <= ~req_o.addr;
    end
  end
endmodule : dms_master_model
`default_nettype wire

// ===== testbench/dms_status_bank_asserts.sv
// Port checks for the drive monitor status bank
`timescale 1ns/10ps
`default_nettype none
module dms_status_bank_asserts (
  input wire logic sys_clk_i, // Clock
  input wire logic rst_i, // Reset
  input wire dms_pkg::dms_req_t req_i, // Request
  input wire dms_pkg::dms_drive_state_t drive_i, // Drive
  input wire dms_pkg::dms_fault_state_t fault_i, // Faults
  input wire dms_pkg::dms_link_state_t link_i, // Link
  input wire dms_pkg::dms_measure_t measure_i, // Values
  input wire logic [7:0] digital_input_pins_i, // Pins
  input wire dms_pkg::dms_rsp_t rsp_o // Answer
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  logic rd_q;
  logic [15:0] ad_q;
  // Plain read taken last edge, so checks key on its address
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rd_q <= 1'b0;
      ad_q <= 16'h0000;
    end else begin
      rd_q <= req_i.rd & ~req_i.wr;
      ad_q <= req_i.addr;
    end
  end
  property p_ack; (req_i.rd | req_i.wr) |=> rsp_o.ack; endproperty
  a_ack: assert property (p_ack) else $error("no answer");
  property p_idle; !(req_i.rd | req_i.wr) |=> !rsp_o.ack; endproperty
  a_idle: assert property (p_idle) else $error("stray answer");
  property p_wr; req_i.wr |=> rsp_o.err && rsp_o.rdata == 16'h0000; endproperty
  a_wr: assert property (p_wr) else $error("write accepted");
  property p_run; rd_q && ad_q == 16'h0020 |-> rsp_o.rdata[15:8] == 8'h00
    && rsp_o.rdata[0] == $past(drive_i.running); endproperty
  a_run: assert property (p_run) else $error("run bit");
  property p_flt; rd_q && ad_q == 16'h0020 |->
    rsp_o.rdata[3] == $past(|fault_i); endproperty
  a_flt: assert property (p_flt) else $error("fault summary");
  property p_oc; rd_q && ad_q == 16'h0021 |-> rsp_o.rdata[0] ==
    $past(fault_i.excess_current_trip | fault_i.earth_leak_trip); endproperty
  a_oc: assert property (p_oc) else $error("current trip bit");
  property p_lnk; rd_q && ad_q == 16'h0022 |->
    {rsp_o.rdata[15:5], rsp_o.rdata[2:1]} == 13'h0000; endproperty
  a_lnk: assert property (p_lnk) else $error("link spare bits");
  property p_cur; rd_q && ad_q == 16'h0026 |->
    rsp_o.rdata == $past(measure_i.current_monitor_item); endproperty
  a_cur: assert property (p_cur) else $error("current value");
  property p_spr; rd_q && (ad_q == 16'h0029 || ad_q == 16'h002A) |->
    !rsp_o.err && rsp_o.rdata == 16'h0000; endproperty
  a_spr: assert property (p_spr) else $error("spare word");
  property p_din; rd_q && ad_q == 16'h002B |->
    rsp_o.rdata[15:8] == 8'h00; endproperty
  a_din: assert property (p_din) else $error("input high byte");
endmodule : dms_status_bank_asserts
bind dms_status_bank dms_status_bank_asserts u_chk (.sys_clk_i(sys_clk_i),
  .rst_i(rst_i), .req_i(req_i), .drive_i(drive_i), .fault_i(fault_i),
  .link_i(link_i), .measure_i(measure_i),
  .digital_input_pins_i(digital_input_pins_i), .rsp_o(rsp_o));
`default_nettype wire

// ===== testbench/tb_top.sv
// Self-checking bench for the drive monitor status bank
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic sys_clk_i = 1'b0;
  logic rst_i, go, wr;
  logic [15:0] base;
  logic [4:0] cnt;
  logic [5:0] len;
  logic [95:0] rnd;
  logic [7:0] pins;
  dms_pkg::dms_req_t req;
  dms_pkg::dms_drive_state_t drv;
  dms_pkg::dms_fault_state_t flt;
  dms_pkg::dms_link_state_t lnk;
  dms_pkg::dms_measure_t mea;
  dms_pkg::dms_rsp_t rsp;
  logic [16:0] q[$];
  int n_mismatch, checks;
  dms_master_model u_mst (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .go_i(go),
    .wr_i(wr), .base_i(base), .cnt_i(cnt), .req_o(req), .len_o(len));
  dms_status_bank DUT (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .req_i(req),
    .drive_i(drv), .fault_i(flt), .link_i(lnk), .measure_i(mea),
    .digital_input_pins_i(pins), .rsp_o(rsp));
  // Clock, 100 ns period
  initial forever #50 sys_clk_i = ~sys_clk_i;
  // Fault causes folded into the cause word, bit F first
  function automatic logic [15:0] fw(input logic [27:0] v);
    return {v[0], v[1], v[3]|v[2], |v[7:4], v[8], |v[11:9], |v[14:12],
      v[15], |v[17:16], v[18], v[19], |v[21:20], |v[23:22], v[24], v[25],
      |v[27:26]};
  endfunction : fw
  // Expected word for register 0x20 plus i
  function automatic logic [15:0] ev(input int i);
    case (i)
      0: return {8'h00, drv[0], drv[1], drv[2], drv[3], |fw(flt), drv[4],
        drv[5], drv[6]};
      1: return fw(flt);
      2: return {11'h000, lnk[0], lnk[1], 2'h0, lnk[2]};
      9, 10: return 16'h0000;
      11: return {8'h00, pins};
      default: return mea[95-16*(i-3) -: 16];
    endcase
  endfunction : ev
  task automatic end_sim();
    $display("n_mismatch=%0d checks=%0d", n_mismatch, checks);
    if (n_mismatch == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : end_sim
  // Note expectations, start the master, wait for all answers
  task automatic xfer(input logic w, input int b, input int n);
    int k;
    for (k = b; k < b + n; k++) begin
      if (w || k < 32 || k > 43) q.push_back(17'h10000);
      else q.push_back({1'b0, ev(k - 32)});
    end
    go <= 1'b1;
    wr <= w;
    base <= b[15:0];
    cnt <= n[4:0];
    @(posedge sys_clk_i);
    go <= 1'b0;
    for (k = 0; k < 100 && q.size() > 0; k++) @(posedge sys_clk_i);
    if (q.size() > 0) begin
      n_mismatch++;
      end_sim();
    end
  endtask : xfer
  // Answer watcher takes the oldest note
  always @(posedge sys_clk_i) begin
    if (rsp.ack === 1'b1) begin
      checks++;
      if (q.size() == 0 || {rsp.err, rsp.rdata} !== q[0]) begin
        $display("BAD rsp exp %h got %h", q.size() ? q[0] : 17'h0,
          {rsp.err, rsp.rdata});
        n_mismatch++;
      end
      if (q.size() > 0) void'(q.pop_front());
    end
  end
  initial begin
    rst_i = 1'b1;
    {go, wr, base, cnt, pins} = '0;
    {drv, flt, lnk, mea} = '0;
    n_mismatch = 0;
    checks = 0;
    void'($urandom(47288));
    repeat (16) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    repeat (2) @(posedge sys_clk_i);
    // Random conditions, full bank polled back to back
    for (int i = 0; i < 30; i++) begin
      rnd = {$urandom, $urandom, $urandom};
      mea <= rnd;
      rnd = {$urandom, $urandom, $urandom};
      drv <= rnd[6:0];
      lnk <= rnd[9:7];
      pins <= rnd[17:10];
      flt <= rnd[45:18] & rnd[73:46] & {$urandom}[27:0];
      repeat (3) @(posedge sys_clk_i); // Input sync needs two edges
      xfer(1'b0, 32, 12);
    end
    // One cause at a time through the fault word
    for (int j = 0; j < 28; j++) begin
      flt <= 28'h1 << j;
      @(posedge sys_clk_i);
      xfer(1'b0, 32, 2);
    end
    xfer(1'b1, 32, 12);
    xfer(1'b0, 31, 14);
    end_sim();
  end
endmodule : tb_top
`default_nettype wire

// ===== verilog/dms_fault_encode.sv
// Folds the individual fault causes into the fault cause word
`timescale 1ns/10ps
`default_nettype none
module dms_fault_encode (
  input wire dms_pkg::dms_fault_state_t fault_i, // Fault causes
  output logic [15:0] word_o, // Fault cause word
  output logic any_o // Any fault present
);
  // Pure combinational grouping; the top registers it
  always_comb begin
    word_o = dms_pkg::RESET_WORD;
    word_o[0] = fault_i.excess_current_trip | fault_i.earth_leak_trip;
    word_o[1] = fault_i.dc_bus_high_trip;
    word_o[2] = fault_i.drive_thermal_trip;
    word_o[3] = fault_i.heatsink_hot_one | fault_i.heatsink_hot_two;
    word_o[4] = fault_i.brake_switch_fault | fault_i.brake_resistor_hot;
    word_o[5] = fault_i.fuse_open;
    word_o[6] = fault_i.pid_feedback_loss;
    word_o[7] = fault_i.external_trip | fault_i.network_external_trip;
    word_o[8] = fault_i.hardware_fault;
    word_o[9] = fault_i.machine_thermal_trip | fault_i.torque_excess_one
                | fault_i.torque_excess_two;
    word_o[10] = fault_i.encoder_wire_break | fault_i.overspeed_trip
                 | fault_i.speed_error_trip;
    word_o[11] = fault_i.bus_low_trip;
    word_o[12] = fault_i.main_bus_low | fault_i.control_supply_fault
                 | fault_i.inrush_circuit_fault | fault_i.power_loss;
    word_o[13] = fault_i.input_phase_fault | fault_i.output_phase_loss;
    word_o[14] = fault_i.serial_comm_error;
    word_o[15] = fault_i.keypad_detached;
    any_o = |word_o;
  end
endmodule : dms_fault_encode
`default_nettype wire

// ===== verilog/dms_pkg.sv
// Package of constants and types for the drive monitor status bank
// Overview of operation
// - Every monitor register is read-only; writes never change contents.
// - Status bit 0 reads 1 while running, 0 while stopped.
// - Status bit 1 reads 1 in reverse, 0 in forward rotation.
// - Status bit 2 reads 1 once startup completes, 0 before.
// - Status bit 3 shows any fault; bit 4 shows data setting error.
// - Status bits 5..7 mirror relay and two photocoupler outputs.
// - Fault bit 0 set on overcurrent or ground fault.
// - Fault bits 1..3: DC bus overvoltage, drive overload, overheat.
// - Fault bits 4..7: brake heat, fuse, PID loss, external fault.
// - Fault bits 8..A: hardware, motor overload/torque, encoder/speed.
// - Fault bits B,C undervoltage family; bit D phase faults.
// - Fault bit E serial comm error; bit F keypad detached.
// - Link status bit 0 writing, bit 3 limit, bit 4 integrity error.
// - Current monitor reports unsigned count of 0.1 ampere steps.
// - Input register bits 0..7 mirror eight input terminals.
package dms_pkg;
  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [15:0] OFS_DRIVE_RUN_STATUS = 16'h0020;
  localparam logic [15:0] OFS_FAULT_CAUSE_FLAGS = 16'h0021;
  localparam logic [15:0] OFS_LINK_WRITE_STATUS = 16'h0022;
  localparam logic [15:0] OFS_SPEED_SETPOINT = 16'h0023;
  localparam logic [15:0] OFS_OUTPUT_SPEED = 16'h0024;
  localparam logic [15:0] OFS_VOLTAGE_SETPOINT = 16'h0025;
  localparam logic [15:0] OFS_CURRENT_MONITOR = 16'h0026;
  localparam logic [15:0] OFS_POWER_MONITOR = 16'h0027;
  localparam logic [15:0] OFS_TORQUE_SETPOINT = 16'h0028;
  localparam logic [15:0] OFS_SPARE_A = 16'h0029;
  localparam logic [15:0] OFS_SPARE_B = 16'h002A;
  localparam logic [15:0] OFS_DIGITAL_INPUTS = 16'h002B;
  // ****************************************
  // Field positions and reset values
  // ****************************************
  localparam int LINK_BIT_WRITING = 0;
  localparam int LINK_BIT_LIMIT = 3;
  localparam int LINK_BIT_INTEGRITY = 4;
  localparam logic [15:0] RESET_WORD = 16'h0000;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [1:0] SYNC_STAGES = 2'h2;

  // Live drive conditions behind the status register
  typedef struct packed {
    logic running;
    logic reverse;
    logic startup_done;
    logic data_setting_error;
    logic relay_contact_output;
    logic photocoupler_output_one;
    logic photocoupler_output_two;
  } dms_drive_state_t;

  // Individual fault causes behind the fault register
  typedef struct packed {
    logic excess_current_trip;
    logic earth_leak_trip;
    logic dc_bus_high_trip;
    logic drive_thermal_trip;
    logic heatsink_hot_one;
    logic heatsink_hot_two;
    logic brake_switch_fault;
    logic brake_resistor_hot;
    logic fuse_open;
    logic pid_feedback_loss;
    logic external_trip;
    logic network_external_trip;
    logic hardware_fault;
    logic machine_thermal_trip;
    logic torque_excess_one;
    logic torque_excess_two;
    logic encoder_wire_break;
    logic overspeed_trip;
    logic speed_error_trip;
    logic bus_low_trip;
    logic main_bus_low;
    logic control_supply_fault;
    logic inrush_circuit_fault;
    logic power_loss;
    logic input_phase_fault;
    logic output_phase_loss;
    logic serial_comm_error;
    logic keypad_detached;
  } dms_fault_state_t;

  // Parameter write progress of the data link
  typedef struct packed {
    logic writing;
    logic limit_error;
    logic integrity_error;
  } dms_link_state_t;

  // Internal measured values, one word each
  typedef struct packed {
    logic [15:0] speed_setpoint;
    logic [15:0] output_speed;
    logic [15:0] voltage_setpoint;
    logic [15:0] current_monitor_item;
    logic [15:0] output_power;
    logic [15:0] torque_setpoint;
  } dms_measure_t;

  // Register read request from the protocol engine
  typedef struct packed {
    logic rd;
    logic wr;
    logic [15:0] addr;
    logic [15:0] wdata;
  } dms_req_t;

  // Read answer back to the protocol engine
  typedef struct packed {
    logic ack;
    logic err;
    logic [15:0] rdata;
  } dms_rsp_t;
endpackage : dms_pkg

// ===== verilog/dms_status_bank.sv
// Top of the read-only drive monitor status bank
`timescale 1ns/10ps
`default_nettype none
module dms_status_bank (
  input wire logic sys_clk_i, // System clock, 10 MHz
  input wire logic rst_i, // Async reset, active high
  input wire dms_pkg::dms_req_t req_i, // Register request
  input wire dms_pkg::dms_drive_state_t drive_i, // Drive conditions
  input wire dms_pkg::dms_fault_state_t fault_i, // Fault causes
  input wire dms_pkg::dms_link_state_t link_i, // Link write state
  input wire dms_pkg::dms_measure_t measure_i, // Measured values
  input wire logic [7:0] digital_input_pins_i, // Raw input terminals
  output dms_pkg::dms_rsp_t rsp_o // Registered answer
);
  // ****************************************
  // Live register images
  // ****************************************
  logic [15:0] drive_run_status;
  logic [15:0] fault_cause_flags;
  logic [15:0] link_write_status;
  logic [15:0] digital_input_levels;
  logic [15:0] fault_word;
  logic fault_any;
  logic [7:0] input_levels;
  logic [15:0] next_rdata;
  logic next_hit;

  // Input terminals come from pins, so synchronise first
  dms_sync #(
    .WIDTH(8)
  ) u_input_sync (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .async_i(digital_input_pins_i),
    .sync_o(input_levels)
  );

  dms_fault_encode u_fault_encode (
    .fault_i(fault_i),
    .word_o(fault_word),
    .any_o(fault_any)
  );

  // Status image, unused upper byte held at zero
  always_comb begin
    drive_run_status = dms_pkg::RESET_WORD;
    drive_run_status[0] = drive_i.running;
    drive_run_status[1] = drive_i.reverse;
    drive_run_status[2] = drive_i.startup_done;
    drive_run_status[3] = fault_any;
    drive_run_status[4] = drive_i.data_setting_error;
    drive_run_status[5] = drive_i.relay_contact_output;
    drive_run_status[6] = drive_i.photocoupler_output_one;
    drive_run_status[7] = drive_i.photocoupler_output_two;
  end

  // Fault image straight from the encoder
  always_comb begin
    fault_cause_flags = fault_word;
  end

  // Link image, unused bits zero
  always_comb begin
    link_write_status = dms_pkg::RESET_WORD;
    link_write_status[dms_pkg::LINK_BIT_WRITING] = link_i.writing;
    link_write_status[dms_pkg::LINK_BIT_LIMIT] = link_i.limit_error;
    link_write_status[dms_pkg::LINK_BIT_INTEGRITY] =
      link_i.integrity_error;
  end

  // Inputs in the low byte, first terminal in bit 0
  always_comb begin
    digital_input_levels = {dms_pkg::RESET_BYTE, input_levels};
  end

  // ****************************************
  // Read decode
  // ****************************************
  // Unmapped addresses answer with an error and zero data
  always_comb begin
    next_rdata = dms_pkg::RESET_WORD;
    next_hit = 1'b1;
    unique case (req_i.addr)
      dms_pkg::OFS_DRIVE_RUN_STATUS: next_rdata = drive_run_status;
      dms_pkg::OFS_FAULT_CAUSE_FLAGS: next_rdata = fault_cause_flags;
      dms_pkg::OFS_LINK_WRITE_STATUS: next_rdata = link_write_status;
      dms_pkg::OFS_SPEED_SETPOINT: next_rdata = measure_i.speed_setpoint;
      dms_pkg::OFS_OUTPUT_SPEED: next_rdata = measure_i.output_speed;
      dms_pkg::OFS_VOLTAGE_SETPOINT: next_rdata = measure_i.voltage_setpoint;
      dms_pkg::OFS_CURRENT_MONITOR:
        next_rdata = measure_i.current_monitor_item;
      dms_pkg::OFS_POWER_MONITOR: next_rdata = measure_i.output_power;
      dms_pkg::OFS_TORQUE_SETPOINT: next_rdata = measure_i.torque_setpoint;
      dms_pkg::OFS_SPARE_A: next_rdata = dms_pkg::RESET_WORD;
      dms_pkg::OFS_SPARE_B: next_rdata = dms_pkg::RESET_WORD;
      dms_pkg::OFS_DIGITAL_INPUTS: next_rdata = digital_input_levels;
      default: next_hit = 1'b0;
    endcase
  end

  // ****************************************
  // Answer register
  // ****************************************
  // Whole word captured on one edge so fields never tear
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rsp_o <= '0;
    end else begin
      rsp_o.ack <= req_i.rd | req_i.wr;
      // Writes are refused: nothing stored, error flagged
      rsp_o.err <= (req_i.rd & ~next_hit) | req_i.wr;
      if (req_i.rd && next_hit) begin
        rsp_o.rdata <= next_rdata;
      end else if (req_i.rd || req_i.wr) begin
        rsp_o.rdata <= dms_pkg::RESET_WORD;
      end
    end
  end
endmodule : dms_status_bank
`default_nettype wire

// ===== verilog/dms_sync.sv
// Two-stage synchroniser for a bus of pin levels
`timescale 1ns/10ps
`default_nettype none
module dms_sync #(
  parameter int WIDTH = 8
) (
  input wire logic sys_clk_i, // System clock
  input wire logic rst_i, // Async reset, active high
  input wire logic [WIDTH-1:0] async_i, // Raw pin levels
  output logic [WIDTH-1:0] sync_o // Levels in clock domain
);
  logic [WIDTH-1:0] stage_one;

  // First stage feeds only the second stage
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      stage_one <= '0;
      sync_o <= '0;
    end else begin
      stage_one <= async_i;
      sync_o <= stage_one;
    end
  end
endmodule : dms_sync
`default_nettype wire
